// [testbench/testbench.sv]
// register and pattern transfer tests for the timing pattern unit
`timescale 1ns/1ps
module testbench
	import tpu_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	tpu_bus_req_t bus = '0;
	logic [15:0] rdata;
	logic [3:0] cmp_match;
	logic [15:0] pins;
	logic [15:0] pins_oe_n;
	logic tm_req = 1'b0;
	logic [1:0] tm_chan = 2'h0;
	logic [3:0] tm_delay = 4'h0;
	int err_count = 0;
	int n_checks = 0;

	always #25 clk = ~clk;

	tpu_pattern_out DUT (
		.clk_i(clk),
		.rst_n_i(rst_n),
		.bus_i(bus),
		.rdata_o(rdata),
		.cmp_match_i(cmp_match),
		.pins_o(pins),
		.pins_oe_n_o(pins_oe_n)
	);

	tpu_timer_model timer (
		.clk_i(clk),
		.rst_n_i(rst_n),
		.req_i(tm_req),
		.chan_i(tm_chan),
		.delay_i(tm_delay),
		.cmp_match_o(cmp_match)
	);

	// =========================================================
	// shared tasks
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [27:0] a, input logic [15:0] d);
		@(posedge clk);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [27:0] a, input logic [15:0] exp);
		@(posedge clk);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge clk);
		bus.rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask

	// pins must hold during the pulse and change one edge later
	task automatic fire(input logic [1:0] ch, input logic [3:0] dly, input logic [15:0] exp_pre,
		input logic [15:0] exp_post);
		int i;
		@(posedge clk);
		tm_req <= 1'b1;
		tm_chan <= ch;
		tm_delay <= dly;
		@(posedge clk);
		tm_req <= 1'b0;
		for (i = 0; i < 20 && cmp_match == 4'h0; i++) begin
			@(posedge clk);
			#1;
		end
		chk({12'h000, cmp_match}, 16'h1 << ch);
		chk(pins, exp_pre);
		@(posedge clk);
		#1;
		chk(pins, exp_post);
	endtask

	task automatic summarize();
		if (err_count == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	initial begin
		#100000;
		err_count++;
		summarize();
	end

	// =========================================================
	// main sequence
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rd(TPU_OFS_PIN_FUNC_UPPER, 16'h0000);
		rd(TPU_OFS_PORT_OUT, 16'h0000);
		rd(TPU_OFS_TRIG_SEL, 16'h00ff);
		rd(TPU_OFS_NEXT_A_HIGH, 16'h0000);
		rd(TPU_OFS_NEXT_B_HIGH, 16'h0000);
		chk(pins_oe_n, 16'hffff);
		wr(TPU_OFS_PIN_FUNC_LOWER, 16'h5555);
		rd(TPU_OFS_PIN_FUNC_LOWER, 16'h5555);
		chk(pins_oe_n, 16'hff00);
		wr(TPU_OFS_PIN_FUNC_UPPER, 16'h5555);
		rd(TPU_OFS_PIN_FUNC_UPPER, 16'h5555);
		chk(pins_oe_n, 16'h0000);
		// a mode other than pattern releases the pin
		wr(TPU_OFS_PIN_FUNC_LOWER, 16'h5556);
		rd(TPU_OFS_PIN_FUNC_LOWER, 16'h5556);
		chk(pins_oe_n, 16'h0001);
		wr(TPU_OFS_PIN_FUNC_LOWER, 16'h5555);
		wr(TPU_OFS_PORT_OUT, 16'h1234);
		rd(TPU_OFS_PORT_OUT, 16'h1234);
		chk(pins, 16'h1234);
		// shared trigger for both pairs after reset
		wr(TPU_OFS_NEXT_A_HIGH, 16'h00a5);
		wr(TPU_OFS_NEXT_A_LOW, 16'h00ff);
		rd(TPU_OFS_NEXT_A_HIGH, 16'h00a5);
		rd(TPU_OFS_NEXT_A_LOW, 16'h00ff);
		wr(TPU_OFS_NEXT_EN_A, 16'h00ff);
		rd(TPU_OFS_NEXT_EN_A, 16'h00ff);
		fire(2'd3, 4'h0, 16'h1234, 16'h12a5);
		wr(TPU_OFS_PORT_OUT, 16'hffff);
		rd(TPU_OFS_PORT_OUT, 16'hffa5);
		// split triggers: g0 ch0, g1 ch1, g2 ch2, g3 ch3
		wr(TPU_OFS_TRIG_SEL, 16'h00e4);
		rd(TPU_OFS_TRIG_SEL, 16'h00e4);
		rd(TPU_OFS_NEXT_A_HIGH, 16'h00af);
		rd(TPU_OFS_NEXT_A_LOW, 16'h00f5);
		wr(TPU_OFS_NEXT_A_HIGH, 16'h003f);
		wr(TPU_OFS_NEXT_A_LOW, 16'h00fc);
		rd(TPU_OFS_NEXT_A_HIGH, 16'h003f);
		rd(TPU_OFS_NEXT_A_LOW, 16'h00fc);
		fire(2'd1, 4'h3, 16'hffa5, 16'hff35);
		fire(2'd0, 4'h0, 16'hff35, 16'hff3c);
		wr(TPU_OFS_NEXT_EN_B, 16'h000f);
		rd(TPU_OFS_NEXT_EN_B, 16'h000f);
		wr(TPU_OFS_NEXT_B_HIGH, 16'h009f);
		wr(TPU_OFS_NEXT_B_LOW, 16'h00f6);
		rd(TPU_OFS_NEXT_B_HIGH, 16'h009f);
		rd(TPU_OFS_NEXT_B_LOW, 16'h00f6);
		fire(2'd2, 4'h1, 16'hff3c, 16'hf63c);
		// group 3 fires but its bits are disabled
		fire(2'd3, 4'h0, 16'hf63c, 16'hf63c);
		// back to one shared trigger
		wr(TPU_OFS_TRIG_SEL, 16'h00ff);
		rd(TPU_OFS_NEXT_B_HIGH, 16'h0096);
		wr(TPU_OFS_NEXT_B_LOW, 16'h00ff);
		rd(TPU_OFS_NEXT_B_LOW, 16'h00ff);
		rd(TPU_OFS_NEXT_B_HIGH, 16'h0096);
		wr(TPU_OFS_NEXT_B_HIGH, 16'h0071);
		fire(2'd3, 4'h2, 16'hf63c, 16'hf13c);
		rd(28'h5fffffa, 16'h0000);
		// second reset in mid-run
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rd(TPU_OFS_NEXT_A_HIGH, 16'h0000);
		rd(TPU_OFS_NEXT_B_HIGH, 16'h0000);
		rd(TPU_OFS_PIN_FUNC_LOWER, 16'h0000);
		rd(TPU_OFS_TRIG_SEL, 16'h00ff);
		rd(TPU_OFS_NEXT_EN_A, 16'h0000);
		chk(pins, 16'h0000);
		chk(pins_oe_n, 16'hffff);
		summarize();
	end
endmodule

// [testbench/tpu_timer_model.sv]
// behavioural timer model issuing compare-match pulses on request
`timescale 1ns/1ps
module tpu_timer_model
	import tpu_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic req_i,
	input wire logic [1:0] chan_i,
	input wire logic [3:0] delay_i,
	output logic [3:0] cmp_match_o
);
	// =========================================================
	// delayed one-cycle pulse, so prompt and slow matches both occur
	logic armed_reg;
	logic [3:0] cnt_reg;
	logic [1:0] chan_reg;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			armed_reg <= 1'b0;
			cnt_reg <= 4'h0;
			chan_reg <= 2'h0;
			cmp_match_o <= 4'h0;
		end else begin
			cmp_match_o <= 4'h0;
			if (req_i) begin
				armed_reg <= 1'b1;
				cnt_reg <= delay_i;
				chan_reg <= chan_i;
			end else if (armed_reg && cnt_reg == 4'h0) begin
				armed_reg <= 1'b0;
				cmp_match_o[chan_reg] <= 1'b1;
			end else if (armed_reg) begin
				cnt_reg <= cnt_reg - 4'h1;
			end
		end
	end
endmodule

// [verilog/tpu_group_xfer.sv]
// one 4-bit output group: trigger selection and gated transfer
`timescale 1ns/1ps
module tpu_group_xfer
	import tpu_pkg::*;
(
	input wire logic [1:0] sel_i,
	input wire logic [3:0] cmp_match_i,
	input wire logic [3:0] enable_i,
	input wire logic [3:0] next_i,
	input wire logic [3:0] cur_i,
	output logic fire_o,
	output logic [3:0] out_o
);

	// =========================================================
	// trigger and transfer
	always_comb begin
		fire_o = cmp_match_i[sel_i]; // RL16
		if (fire_o) begin
			out_o = (next_i & enable_i) | (cur_i & ~enable_i); // RL15
		end else begin
			out_o = cur_i;
		end
	end

endmodule

// [verilog/tpu_pattern_out.sv]
// timing pattern unit: next data registers, port output data and pins
`timescale 1ns/1ps
module tpu_pattern_out
	import tpu_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire tpu_bus_req_t bus_i,
	output logic [15:0] rdata_o,
	input wire logic [3:0] cmp_match_i,
	output logic [15:0] pins_o,
	output logic [15:0] pins_oe_n_o
);

	// =========================================================
	// registers
	logic [15:0] pfu_reg;
	logic [15:0] pfu_next;
	logic [15:0] pfl_reg;
	logic [15:0] pfl_next;
	logic [15:0] pod_reg;
	logic [15:0] pod_next;
	logic [7:0] trig_reg;
	logic [7:0] trig_next;
	logic [7:0] nea_reg;
	logic [7:0] nea_next;
	logic [7:0] neb_reg;
	logic [7:0] neb_next;
	logic [7:0] nda_reg;
	logic [7:0] nda_next;
	logic [7:0] ndb_reg;
	logic [7:0] ndb_next;
	logic [15:0] rdata_reg;
	logic [15:0] rdata_next;
	logic [15:0] oe_n_reg;
	logic [15:0] oe_n_next;

	logic [15:0] en16;
	logic [15:0] nd16;
	logic [15:0] pod_wr;
	logic [15:0] pod_xfer;
	logic [3:0] fire;
	logic [31:0] mode32;
	logic same_a;
	logic same_b;

	// =========================================================
	// address decode
	function automatic logic hit(input logic [27:0] addr, input logic [27:0] ofs);
		hit = (addr & TPU_ADDR_MASK) == (ofs & TPU_ADDR_MASK);
	endfunction

	logic h_pfu;
	logic h_pfl;
	logic h_pod;
	logic h_trig;
	logic h_nea;
	logic h_neb;
	logic h_bh;
	logic h_ah;
	logic h_bl;
	logic h_al;

	assign h_pfu = hit(bus_i.addr, TPU_OFS_PIN_FUNC_UPPER);
	assign h_pfl = hit(bus_i.addr, TPU_OFS_PIN_FUNC_LOWER);
	assign h_pod = hit(bus_i.addr, TPU_OFS_PORT_OUT);
	assign h_trig = hit(bus_i.addr, TPU_OFS_TRIG_SEL);
	assign h_nea = hit(bus_i.addr, TPU_OFS_NEXT_EN_A);
	assign h_neb = hit(bus_i.addr, TPU_OFS_NEXT_EN_B);
	assign h_bh = hit(bus_i.addr, TPU_OFS_NEXT_B_HIGH);
	assign h_ah = hit(bus_i.addr, TPU_OFS_NEXT_A_HIGH);
	assign h_bl = hit(bus_i.addr, TPU_OFS_NEXT_B_LOW);
	assign h_al = hit(bus_i.addr, TPU_OFS_NEXT_A_LOW);

	// pair layout follows the live trigger selection
	assign same_a = trig_reg[3:2] == trig_reg[1:0];
	assign same_b = trig_reg[7:6] == trig_reg[5:4];

	assign en16 = {neb_reg, nea_reg};
	assign nd16 = {ndb_reg, nda_reg};
	assign mode32 = {pfu_reg, pfl_reg};

	// =========================================================
	// pin function and trigger select
	always_comb begin
		pfu_next = pfu_reg;
		pfl_next = pfl_reg;
		trig_next = trig_reg;
		nea_next = nea_reg;
		neb_next = neb_reg;
		if (bus_i.wr && h_pfu) begin
			pfu_next = bus_i.wdata; // RL3
		end
		if (bus_i.wr && h_pfl) begin
			pfl_next = bus_i.wdata; // RL3
		end
		if (bus_i.wr && h_trig) begin
			trig_next = bus_i.wdata[7:0]; // RL16
		end
		if (bus_i.wr && h_nea) begin
			nea_next = bus_i.wdata[7:0]; // RL15
		end
		if (bus_i.wr && h_neb) begin
			neb_next = bus_i.wdata[7:0]; // RL15
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			pfu_reg <= TPU_RST_PIN_FUNC; // RL3
			pfl_reg <= TPU_RST_PIN_FUNC; // RL3
		end else begin
			pfu_reg <= pfu_next;
			pfl_reg <= pfl_next;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			trig_reg <= TPU_RST_TRIG_SEL; // RL16
			nea_reg <= TPU_RST_NEXT_EN;
			neb_reg <= TPU_RST_NEXT_EN;
		end else begin
			trig_reg <= trig_next;
			nea_reg <= nea_next;
			neb_reg <= neb_next;
		end
	end

	// =========================================================
	// next data registers
	// writes to reserved nibbles are dropped, so written ones never land
	always_comb begin
		nda_next = nda_reg;
		if (bus_i.wr && h_ah) begin
			if (same_a) begin
				nda_next = bus_i.wdata[7:0]; // RL10
			end else begin
				nda_next[7:4] = bus_i.wdata[7:4]; // RL11 RL14
			end
		end
		if (bus_i.wr && h_al && !same_a) begin
			nda_next[3:0] = bus_i.wdata[3:0]; // RL11
		end
	end

	always_comb begin
		ndb_next = ndb_reg;
		if (bus_i.wr && h_bh) begin
			if (same_b) begin
				ndb_next = bus_i.wdata[7:0]; // RL12
			end else begin
				ndb_next[7:4] = bus_i.wdata[7:4]; // RL13 RL14
			end
		end
		if (bus_i.wr && h_bl && !same_b) begin
			ndb_next[3:0] = bus_i.wdata[3:0]; // RL13
		end
	end

	// only reset clears these; no low-power entry touches them
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			nda_reg <= TPU_RST_NEXT_DATA; // RL8
			ndb_reg <= TPU_RST_NEXT_DATA; // RL9
		end else begin
			nda_reg <= nda_next;
			ndb_reg <= ndb_next;
		end
	end

	// =========================================================
	// port output data: software write, then group transfers
	always_comb begin
		pod_wr = pod_reg;
		if (bus_i.wr && h_pod) begin
			pod_wr = (pod_reg & en16) | (bus_i.wdata & ~en16); // RL5
		end
	end

	// write and transfer touch disjoint bits, so neither is lost
	genvar g;
	generate
		for (g = 0; g < TPU_GROUPS; g++) begin : g_grp
			tpu_group_xfer u_xfer (
				.sel_i(trig_reg[g*TPU_SEL_W +: TPU_SEL_W]),
				.cmp_match_i(cmp_match_i),
				.enable_i(en16[g*TPU_GRP_W +: TPU_GRP_W]),
				.next_i(nd16[g*TPU_GRP_W +: TPU_GRP_W]),
				.cur_i(pod_wr[g*TPU_GRP_W +: TPU_GRP_W]),
				.fire_o(fire[g]),
				.out_o(pod_xfer[g*TPU_GRP_W +: TPU_GRP_W]) // RL6 RL7
			);
		end
	endgenerate

	assign pod_next = pod_xfer;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			pod_reg <= TPU_RST_PORT_OUT; // RL4
		end else begin
			pod_reg <= pod_next; // RL17
		end
	end

	// =========================================================
	// pin drive
	// pins are only driven once software picked the pattern mode
	genvar p;
	generate
		for (p = 0; p < TPU_PINS; p++) begin : g_pin
			assign oe_n_next[p] = mode32[p*2 +: 2] != TPU_MODE_PATTERN; // RL1 RL2
		end
	endgenerate

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			oe_n_reg <= '1;
		end else begin
			oe_n_reg <= oe_n_next; // RL1
		end
	end

	// =========================================================
	// read data, one cycle after the strobe
	always_comb begin
		rdata_next = TPU_UNMAPPED;
		if (bus_i.rd) begin
			if (h_pfu) begin
				rdata_next = pfu_reg;
			end else if (h_pfl) begin
				rdata_next = pfl_reg;
			end else if (h_pod) begin
				rdata_next = pod_reg; // RL4
			end else if (h_trig) begin
				rdata_next = {TPU_BYTE_PAD, trig_reg};
			end else if (h_nea) begin
				rdata_next = {TPU_BYTE_PAD, nea_reg};
			end else if (h_neb) begin
				rdata_next = {TPU_BYTE_PAD, neb_reg};
			end else if (h_ah) begin
				rdata_next = {TPU_BYTE_PAD, same_a ? nda_reg : {nda_reg[7:4], TPU_RSV_NIB}}; // RL10 RL11
			end else if (h_al) begin
				rdata_next = {TPU_BYTE_PAD, same_a ? TPU_RSV_BYTE : {TPU_RSV_NIB, nda_reg[3:0]}}; // RL10 RL11
			end else if (h_bh) begin
				rdata_next = {TPU_BYTE_PAD, same_b ? ndb_reg : {ndb_reg[7:4], TPU_RSV_NIB}}; // RL12 RL13
			end else if (h_bl) begin
				rdata_next = {TPU_BYTE_PAD, same_b ? TPU_RSV_BYTE : {TPU_RSV_NIB, ndb_reg[3:0]}}; // RL12 RL13
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			rdata_reg <= TPU_RST_RDATA;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	assign rdata_o = rdata_reg;
	assign pins_o = pod_reg;
	assign pins_oe_n_o = oe_n_reg;

	// =========================================================
	// assertions
	property p_pin_mode; // RL3
		@(posedge clk_i) disable iff (!rst_n_i)
		bus_i.wr && h_pfu |=> pfu_reg == $past(bus_i.wdata);
	endproperty
	a_pin_mode: assert property (p_pin_mode) else $error("pin function write not stored"); // RL3

	property p_oe_follows_mode; // RL1
		@(posedge clk_i) disable iff (!rst_n_i)
		(pfl_reg[1:0] == TPU_MODE_PATTERN) ##1 (pfl_reg[1:0] == TPU_MODE_PATTERN) |-> !pins_oe_n_o[0];
	endproperty
	a_oe_follows_mode: assert property (p_oe_follows_mode) else $error("pattern pin 0 not driven"); // RL1

	property p_ro_bits; // RL5
		@(posedge clk_i) disable iff (!rst_n_i)
		bus_i.wr && h_pod && cmp_match_i == 4'h0 |=> ((pod_reg ^ $past(pod_reg)) & $past(en16)) == 16'h0000;
	endproperty
	a_ro_bits: assert property (p_ro_bits) else $error("enabled output bit changed by software"); // RL5

	property p_xfer_a; // RL6
		@(posedge clk_i) disable iff (!rst_n_i)
		cmp_match_i[trig_reg[1:0]] |=> (pins_o[3:0] & $past(nea_reg[3:0])) == ($past(nda_reg[3:0]) & $past(nea_reg[3:0]));
	endproperty
	a_xfer_a: assert property (p_xfer_a) else $error("group 0 transfer wrong"); // RL6

	property p_xfer_b; // RL7
		@(posedge clk_i) disable iff (!rst_n_i)
		cmp_match_i[trig_reg[7:6]] |=> (pins_o[15:12] & $past(neb_reg[7:4])) == ($past(ndb_reg[7:4]) & $past(neb_reg[7:4]));
	endproperty
	a_xfer_b: assert property (p_xfer_b) else $error("group 3 transfer wrong"); // RL7

	property p_disabled_hold; // RL15
		@(posedge clk_i) disable iff (!rst_n_i)
		!(bus_i.wr && h_pod) |=> ((pod_reg ^ $past(pod_reg)) & ~$past(en16)) == 16'h0000;
	endproperty
	a_disabled_hold: assert property (p_disabled_hold) else $error("disabled bit took a transfer"); // RL15

	property p_no_match_hold; // RL17
		@(posedge clk_i) disable iff (!rst_n_i)
		cmp_match_i == 4'h0 && !(bus_i.wr && h_pod) |=> $stable(pins_o);
	endproperty
	a_no_match_hold: assert property (p_no_match_hold) else $error("output moved without match"); // RL17

	property p_rsv_a; // RL10
		@(posedge clk_i) disable iff (!rst_n_i)
		bus_i.rd && h_al && same_a |=> rdata_o == 16'h00ff;
	endproperty
	a_rsv_a: assert property (p_rsv_a) else $error("reserved byte of A not all ones"); // RL10

	property p_nib_b; // RL13
		@(posedge clk_i) disable iff (!rst_n_i)
		bus_i.rd && h_bh && !same_b |=> rdata_o[3:0] == 4'hf && rdata_o[7:4] == $past(ndb_reg[7:4]);
	endproperty
	a_nib_b: assert property (p_nib_b) else $error("split B upper address wrong"); // RL13

	property p_nd_stable; // RL8
		@(posedge clk_i) disable iff (!rst_n_i)
		!(bus_i.wr && (h_ah || h_al)) |=> $stable(nda_reg);
	endproperty
	a_nd_stable: assert property (p_nd_stable) else $error("next data A changed without write"); // RL8

	property p_split_write_a; // RL11
		@(posedge clk_i) disable iff (!rst_n_i)
		bus_i.wr && h_al && !same_a |=> nda_reg[3:0] == $past(bus_i.wdata[3:0]) && $stable(nda_reg[7:4]);
	endproperty
	a_split_write_a: assert property (p_split_write_a) else $error("group 0 nibble write wrong"); // RL11

	property p_xfer_g1;
		@(posedge clk_i) disable iff (!rst_n_i)
		fire[1] |=> (pins_o[7:4] & $past(nea_reg[7:4])) == ($past(nda_reg[7:4]) & $past(nea_reg[7:4]));
	endproperty
	a_xfer_g1: assert property (p_xfer_g1) else $error("group 1 transfer wrong"); // RL6

	property p_xfer_g2;
		@(posedge clk_i) disable iff (!rst_n_i)
		fire[2] |=> (pins_o[11:8] & $past(neb_reg[3:0])) == ($past(ndb_reg[3:0]) & $past(neb_reg[3:0]));
	endproperty
	a_xfer_g2: assert property (p_xfer_g2) else $error("group 2 transfer wrong"); // RL7

endmodule

// [verilog/tpu_pkg.sv]
// constants, field layouts and bus carrier for the timing pattern unit
// Operation
// [RL1] sixteen dual-use port pins carry pattern outputs
// [RL2] software sets pin mode to pattern first
// [RL3] two 16-bit pin function registers, reset zero
// [RL4] 16-bit port output data register, reset zero
// [RL5] enabled output bits ignore software writes
// [RL6] next data A feeds pins 7-0
// [RL7] next data B feeds pins 15-8
// [RL8] next data A resets zero, standby keeps
// [RL9] next data B resets zero, standby keeps
// [RL10] A shared trigger: one byte, other reserved
// [RL11] A split triggers: nibble per address
// [RL12] B shared trigger: one byte, other reserved
// [RL13] B split triggers: nibble per address
// [RL14] software writes ones to reserved bits
// [RL15] enable bits gate each bit's transfer
// [RL16] per-group trigger select, resets to channel 3
// [RL17] output updates one clock after match
package tpu_pkg;

	// =========================================================
	// register offsets
	localparam logic [27:0] TPU_OFS_PORT_OUT = 28'h5ffffc2;
	localparam logic [27:0] TPU_OFS_PIN_FUNC_UPPER = 28'h5ffffcc;
	localparam logic [27:0] TPU_OFS_PIN_FUNC_LOWER = 28'h5ffffce;
	localparam logic [27:0] TPU_OFS_TRIG_SEL = 28'h5fffff1;
	localparam logic [27:0] TPU_OFS_NEXT_EN_B = 28'h5fffff2;
	localparam logic [27:0] TPU_OFS_NEXT_EN_A = 28'h5fffff3;
	localparam logic [27:0] TPU_OFS_NEXT_B_HIGH = 28'h5fffff4;
	localparam logic [27:0] TPU_OFS_NEXT_A_HIGH = 28'h5fffff5;
	localparam logic [27:0] TPU_OFS_NEXT_B_LOW = 28'h5fffff6;
	localparam logic [27:0] TPU_OFS_NEXT_A_LOW = 28'h5fffff7;
	// middle address bits are not decoded
	localparam logic [27:0] TPU_ADDR_MASK = 28'hf0001ff;

	// =========================================================
	// reset values
	localparam logic [15:0] TPU_RST_PIN_FUNC = 16'h0000;
	localparam logic [15:0] TPU_RST_PORT_OUT = 16'h0000;
	localparam logic [7:0] TPU_RST_NEXT_DATA = 8'h00;
	localparam logic [7:0] TPU_RST_NEXT_EN = 8'h00;
	localparam logic [7:0] TPU_RST_TRIG_SEL = 8'hff;
	localparam logic [15:0] TPU_RST_RDATA = 16'h0000;

	// =========================================================
	// fields and encodings
	localparam int TPU_GROUPS = 4;
	localparam int TPU_GRP_W = 4;
	localparam int TPU_SEL_W = 2;
	localparam int TPU_PINS = 16;
	localparam logic [1:0] TPU_MODE_PATTERN = 2'b01;
	localparam logic [7:0] TPU_RSV_BYTE = 8'hff;
	localparam logic [3:0] TPU_RSV_NIB = 4'hf;
	localparam logic [7:0] TPU_BYTE_PAD = 8'h00;
	localparam logic [15:0] TPU_UNMAPPED = 16'h0000;
	// clock edges from a match pulse to the updated output
	localparam int TPU_XFER_LAT = 1;

	typedef struct packed {
		logic [27:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} tpu_bus_req_t;

endpackage
